// >>> xccs_pkg.sv
// package: register map, field layout and types of the transceiver core clock select
package xccs_pkg;

   // channel count of one transceiver group
   localparam int unsigned XCCS_NCH = 4;

   // register byte offsets on the wishbone bus
   localparam logic [3:0] XCCS_CFG_OFS = 4'h0;
   localparam logic [3:0] XCCS_STAT_OFS = 4'h4;

   // configuration register field positions
   localparam int unsigned XCCS_TX_SHARED_BIT = 0;
   localparam int unsigned XCCS_RX_MODE_LSB = 1;
   localparam int unsigned XCCS_TX_CORE_LSB = 4;
   localparam int unsigned XCCS_RX_CORE_LSB = 8;
   localparam int unsigned XCCS_RX_DIV_LSB = 12;

   // status register field positions
   localparam int unsigned XCCS_STAT_PHASE_LSB = 0;
   localparam int unsigned XCCS_STAT_BUSY_BIT = 4;
   localparam int unsigned XCCS_STAT_REFUSED_BIT = 5;

   // reset values
   localparam logic XCCS_TX_SHARED_RST = 1'b0;
   localparam logic [3:0] XCCS_CORE_EN_RST = 4'h0;
   localparam logic [3:0] XCCS_RX_DIV_RST = 4'h0;
   localparam logic [31:0] XCCS_DATA_ZERO = 32'h0000_0000;

   // read clock source of the receive fifos when no core clock is chosen
   typedef enum logic [1:0] {
      XCCS_RX_SHARED_TX0,
      XCCS_RX_OWN_TX,
      XCCS_RX_OWN_RX,
      XCCS_RX_RESERVED
   } xccs_rx_src_t;

   // incoming clock ticks, one bit per channel, synchronous to clk_i
   typedef struct packed {
      logic [XCCS_NCH-1:0] tx_par;   // transmit parallel output clock
      logic [XCCS_NCH-1:0] rx_par;   // receive parallel output clock
      logic [XCCS_NCH-1:0] tx_core;  // fabric transmit core clock
      logic [XCCS_NCH-1:0] rx_core;  // fabric receive core clock
   } xccs_clk_in_t;

   // selected fifo clock ticks, one bit per channel
   typedef struct packed {
      logic [XCCS_NCH-1:0] tx_wr;    // transmit fifo write clock
      logic [XCCS_NCH-1:0] rx_rd;    // receive fifo read clock
   } xccs_fifo_clk_t;

endpackage : xccs_pkg

// >>> xccs_rx_div2.sv
// receive path divide-by-two stage of one channel's analog front end
`timescale 1ns/100ps
`default_nettype none

module xccs_rx_div2 (
   input wire logic clk_i,      // system clock
   input wire logic rst_i,      // synchronous reset, active high
   input wire logic en_i,       // divider enabled: half rate
   input wire logic tick_i,     // receive parallel clock tick
   output logic tick_o,         // divided tick, combinational
   output logic phase_o         // divider phase, registered
);

   logic phase_r;
   logic phase_nxt;

   // phase flips on each tick while enabled; parked low when off
   always_comb begin
      phase_nxt = phase_r;
      if (!en_i) begin
         phase_nxt = 1'b0;
      end else if (tick_i) begin
         phase_nxt = ~phase_r;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         phase_r <= 1'b0;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   // every second tick passes when enabled, every tick otherwise
   assign tick_o = tick_i & (~en_i | phase_r);
   assign phase_o = phase_r;

endmodule : xccs_rx_div2

`default_nettype wire

// >>> xccs_clock_select.sv
// top: fifo clock source selection for a four-channel transceiver group
// Functional notes
// - each receiver has a divide-by-two stage giving half data rate, no extra pll
// - the divider changes only the receive path; transmit rate stays unchanged
// - transmit fifo write clock is core clock or output clock; core clock wins
// - shared transmit clocking: channel 0 transmit clock writes every transmit fifo
// - per-channel transmit clocking: own transmit clock writes own transmit fifo
// - receive fifo read clock is core clock or output clock; core clock wins
// - shared receive clocking: channel 0 transmit clock reads every receive fifo
// - second receive choice: own transmit clock reads own receive fifo
// - third receive choice: own receive clock reads own receive fifo
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/100ps
`default_nettype none

module xccs_clock_select (
   input wire logic clk_i,                      // system clock, 100 MHz
   input wire logic rst_i,                      // synchronous reset, active high
   input wire logic wb_cyc_i,                   // wishbone cycle
   input wire logic wb_stb_i,                   // wishbone strobe
   input wire logic wb_we_i,                    // wishbone write enable
   input wire logic [3:0] wb_adr_i,             // wishbone byte address
   input wire logic [3:0] wb_sel_i,             // wishbone byte lanes
   input wire logic [31:0] wb_dat_i,            // wishbone write data
   output logic [31:0] wb_dat_o,                // wishbone read data
   output logic wb_ack_o,                       // wishbone acknowledge
   input wire logic fifo_busy_i,                // fifos are transferring data
   input wire xccs_pkg::xccs_clk_in_t clk_in_i, // incoming clock ticks
   output xccs_pkg::xccs_fifo_clk_t fifo_clk_o, // selected fifo clock ticks
   output logic [3:0] rx_div_phase_o            // divider phase per channel
);
   import xccs_pkg::*;

   // configuration state
   logic tx_shared_r;
   logic tx_shared_nxt;
   xccs_rx_src_t rx_mode_r;
   xccs_rx_src_t rx_mode_nxt;
   logic [XCCS_NCH-1:0] tx_core_en_r;
   logic [XCCS_NCH-1:0] tx_core_en_nxt;
   logic [XCCS_NCH-1:0] rx_core_en_r;
   logic [XCCS_NCH-1:0] rx_core_en_nxt;
   logic [XCCS_NCH-1:0] rx_div_en_r;
   logic [XCCS_NCH-1:0] rx_div_en_nxt;
   logic refused_r;
   logic refused_nxt;

   // bus state
   logic ack_r;
   logic ack_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   // clock path state
   xccs_fifo_clk_t fifo_clk_r;
   xccs_fifo_clk_t fifo_clk_nxt;
   logic [XCCS_NCH-1:0] phase_r;
   logic [XCCS_NCH-1:0] phase_nxt;

   // per-channel selection results
   logic [XCCS_NCH-1:0] rx_div_tick;
   logic [XCCS_NCH-1:0] div_phase;
   logic [XCCS_NCH-1:0] tx_sel;
   logic [XCCS_NCH-1:0] rx_sel;

   // bus decode
   logic req;
   logic wr_cfg;
   logic wr_take;
   logic [31:0] cfg_word;
   logic [31:0] stat_word;
   logic [31:0] cfg_new;

   assign req = wb_cyc_i & wb_stb_i;
   // write lands on the edge where the master samples ack
   assign wr_take = req & wb_we_i & ack_r;
   assign wr_cfg = wr_take & (wb_adr_i == XCCS_CFG_OFS);

   // readback images of both registers
   always_comb begin
      cfg_word = XCCS_DATA_ZERO;
      cfg_word[XCCS_TX_SHARED_BIT] = tx_shared_r;
      cfg_word[XCCS_RX_MODE_LSB +: 2] = rx_mode_r;
      cfg_word[XCCS_TX_CORE_LSB +: XCCS_NCH] = tx_core_en_r;
      cfg_word[XCCS_RX_CORE_LSB +: XCCS_NCH] = rx_core_en_r;
      cfg_word[XCCS_RX_DIV_LSB +: XCCS_NCH] = rx_div_en_r;
      stat_word = XCCS_DATA_ZERO;
      stat_word[XCCS_STAT_PHASE_LSB +: XCCS_NCH] = phase_r;
      stat_word[XCCS_STAT_BUSY_BIT] = fifo_busy_i;
      stat_word[XCCS_STAT_REFUSED_BIT] = refused_r;
   end

   // byte lanes merge write data over the current image
   always_comb begin
      cfg_new = cfg_word;
      if (wb_sel_i[0]) begin
         cfg_new[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
         cfg_new[15:8] = wb_dat_i[15:8];
      end
   end

   // classic wishbone: one wait state, ack for one cycle, unmapped reads zero
   always_comb begin
      ack_nxt = req & ~ack_r;
      rdata_nxt = rdata_r;
      if (req && !ack_r) begin
         case (wb_adr_i)
            XCCS_CFG_OFS: begin
               rdata_nxt = cfg_word;
            end
            XCCS_STAT_OFS: begin
               rdata_nxt = stat_word;
            end
            default: begin
               rdata_nxt = XCCS_DATA_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdata_r <= XCCS_DATA_ZERO;
      end else begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // clock selections only move while the fifos are idle
   // the divider enable sits in the same word, so rate changes are gated too
   always_comb begin
      tx_shared_nxt = tx_shared_r;
      rx_mode_nxt = rx_mode_r;
      tx_core_en_nxt = tx_core_en_r;
      rx_core_en_nxt = rx_core_en_r;
      rx_div_en_nxt = rx_div_en_r;
      refused_nxt = refused_r;
      if (wr_cfg && fifo_busy_i) begin
         refused_nxt = 1'b1;
      end else if (wr_cfg) begin
         refused_nxt = 1'b0;
         tx_shared_nxt = cfg_new[XCCS_TX_SHARED_BIT];
         rx_mode_nxt = xccs_rx_src_t'(cfg_new[XCCS_RX_MODE_LSB +: 2]);
         tx_core_en_nxt = cfg_new[XCCS_TX_CORE_LSB +: XCCS_NCH];
         rx_core_en_nxt = cfg_new[XCCS_RX_CORE_LSB +: XCCS_NCH];
         rx_div_en_nxt = cfg_new[XCCS_RX_DIV_LSB +: XCCS_NCH];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tx_shared_r <= XCCS_TX_SHARED_RST;
         rx_mode_r <= XCCS_RX_OWN_RX;
         tx_core_en_r <= XCCS_CORE_EN_RST;
         rx_core_en_r <= XCCS_CORE_EN_RST;
         rx_div_en_r <= XCCS_RX_DIV_RST;
         refused_r <= 1'b0;
      end else begin
         tx_shared_r <= tx_shared_nxt;
         rx_mode_r <= rx_mode_nxt;
         tx_core_en_r <= tx_core_en_nxt;
         rx_core_en_r <= rx_core_en_nxt;
         rx_div_en_r <= rx_div_en_nxt;
         refused_r <= refused_nxt;
      end
   end

   // per-channel clock muxes; the divider sits on the receive clock only
   for (genvar ch = 0; ch < XCCS_NCH; ch++) begin : g_chan
      xccs_rx_div2 u_div (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .en_i(rx_div_en_r[ch]),
         .tick_i(clk_in_i.rx_par[ch]),
         .tick_o(rx_div_tick[ch]),
         .phase_o(div_phase[ch])
      );

      // transmit side never sees the divider
      always_comb begin
         if (tx_core_en_r[ch]) begin
            tx_sel[ch] = clk_in_i.tx_core[ch];
         end else if (tx_shared_r) begin
            tx_sel[ch] = clk_in_i.tx_par[0];
         end else begin
            tx_sel[ch] = clk_in_i.tx_par[ch];
         end
      end

      // core clock overrides every output-clock routing
      always_comb begin
         if (rx_core_en_r[ch]) begin
            rx_sel[ch] = clk_in_i.rx_core[ch];
         end else begin
            case (rx_mode_r)
               XCCS_RX_SHARED_TX0: begin
                  rx_sel[ch] = clk_in_i.tx_par[0];
               end
               XCCS_RX_OWN_TX: begin
                  rx_sel[ch] = clk_in_i.tx_par[ch];
               end
               default: begin
                  // reserved code falls back to the receiver's own clock
                  rx_sel[ch] = rx_div_tick[ch];
               end
            endcase
         end
      end
   end

   // register the selected ticks so every output leaves a flip-flop
   always_comb begin
      fifo_clk_nxt.tx_wr = tx_sel;
      fifo_clk_nxt.rx_rd = rx_sel;
      phase_nxt = div_phase;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fifo_clk_r <= '0;
         phase_r <= '0;
      end else begin
         fifo_clk_r <= fifo_clk_nxt;
         phase_r <= phase_nxt;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdata_r;
   assign fifo_clk_o = fifo_clk_r;
   assign rx_div_phase_o = phase_r;

endmodule : xccs_clock_select

`default_nettype wire

// >>> xccs_ref.svh
// reference selection of fifo clock ticks, shared by the checker and the testbench
function automatic xccs_fifo_clk_t xccs_ref_sel(input logic [15:0] c, input xccs_clk_in_t k,
                                                input logic [3:0] ph);
   xccs_fifo_clk_t f;
   for (int i = 0; i < XCCS_NCH; i++) begin
      f.tx_wr[i] = c[4+i] ? k.tx_core[i] : (c[0] ? k.tx_par[0] : k.tx_par[i]);
      case (c[2:1])
         2'h0: f.rx_rd[i] = k.tx_par[0];
         2'h1: f.rx_rd[i] = k.tx_par[i];
         // divider passes only the tick seen in phase one
         default: f.rx_rd[i] = k.rx_par[i] & (~c[12+i] | ph[i]);
      endcase
      if (c[8+i]) f.rx_rd[i] = k.rx_core[i];
   end
   return f;
endfunction : xccs_ref_sel

// >>> xccs_fabric_model.sv
// fabric side model: output clock ticks and matching core clock ticks
`timescale 1ns/100ps
`default_nettype none
module xccs_fabric_model import xccs_pkg::*; (
   input wire logic clk_i,                    // system clock
   input wire logic rst_i,                    // synchronous reset
   output var xccs_pkg::xccs_clk_in_t clk_in_o // clock ticks to the block
);
   logic [7:0] cnt_r;
   // distinct periods per channel so a wrong route shows up
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 8'h00;
         clk_in_o <= '0;
      end else begin
         cnt_r <= cnt_r + 8'h01;
         for (int i = 0; i < XCCS_NCH; i++) begin
            clk_in_o.tx_par[i] <= (cnt_r % (i + 2)) == 0;
            clk_in_o.tx_core[i] <= (cnt_r % (i + 2)) == 1; // same period, other phase
            clk_in_o.rx_par[i] <= (cnt_r % (i + 3)) == 0;
            clk_in_o.rx_core[i] <= (cnt_r % (i + 3)) == 2; // same period as rx_par
         end
      end
   end
endmodule : xccs_fabric_model
`default_nettype wire

// >>> xccs_clock_select_assertions.sv
// checker for the fifo clock select block
`timescale 1ns/100ps
`default_nettype none
module xccs_clock_select_chk import xccs_pkg::*; (
   input wire logic clk_i,                      // system clock
   input wire logic rst_i,                      // reset
   input wire logic wb_cyc_i,                   // cycle
   input wire logic wb_stb_i,                   // strobe
   input wire logic wb_we_i,                    // write
   input wire logic [3:0] wb_adr_i,             // address
   input wire logic [3:0] wb_sel_i,             // lanes
   input wire logic [31:0] wb_dat_i,            // write data
   input wire logic [31:0] wb_dat_o,            // read data
   input wire logic wb_ack_o,                   // acknowledge
   input wire logic fifo_busy_i,                // fifos busy
   input wire xccs_pkg::xccs_clk_in_t clk_in_i, // ticks in
   input wire xccs_pkg::xccs_fifo_clk_t fifo_clk_o, // ticks out
   input wire logic [3:0] rx_div_phase_o        // divider phase
);
   `include "xccs_ref.svh"
   logic [15:0] cfg_r, cfg_nxt;
   logic ref_r, ref_nxt, wr_cfg;
   logic [15:0] cfg_q;
   xccs_clk_in_t in_q;
   logic [3:0] tx_x, rx_x;
   assign wr_cfg = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i & (wb_adr_i == XCCS_CFG_OFS);
   // last cycle's config and ticks; the phase output lags the divider by one, so it is the phase used then
   assign {tx_x, rx_x} = xccs_ref_sel(cfg_q, in_q, rx_div_phase_o);
   // shadow of the config; a busy write only sets the refused flag
   always_comb begin
      cfg_nxt = cfg_r;
      ref_nxt = ref_r;
      if (wr_cfg) begin
         ref_nxt = fifo_busy_i;
         if (!fifo_busy_i && wb_sel_i[0]) cfg_nxt[7:0] = wb_dat_i[7:0];
         if (!fifo_busy_i && wb_sel_i[1]) cfg_nxt[15:8] = wb_dat_i[15:8];
      end
   end
   always_ff @(posedge clk_i) begin
      cfg_r <= rst_i ? 16'h0004 : cfg_nxt;
      ref_r <= rst_i ? 1'b0 : ref_nxt;
      cfg_q <= cfg_r;
      in_q <= clk_in_i;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_tx_route: assert property ($past(!rst_i) |-> fifo_clk_o.tx_wr == tx_x)
      else $error("tx fifo write clock wrong");
   chk_rx_route: assert property ($past(!rst_i) |-> fifo_clk_o.rx_rd == rx_x)
      else $error("rx fifo read clock wrong");
   chk_div_phase_step: assert property ($past(!rst_i, 2) |-> ((rx_div_phase_o ^ $past(rx_div_phase_o)) &
      $past(cfg_r[15:12], 2)) == $past(cfg_r[15:12] & clk_in_i.rx_par, 2)) else $error("divider phase wrong");
   chk_tx_no_div: assert property ($past(!rst_i && !cfg_r[0] && cfg_r[7:4] == 4'h0) |->
      fifo_clk_o.tx_wr == $past(clk_in_i.tx_par)) else $error("tx clock disturbed");
   chk_ack_one_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
   chk_cfg_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == XCCS_CFG_OFS |->
      wb_dat_o == {16'h0000, cfg_r}) else $error("config read wrong");
   chk_busy_refuse: assert property (wb_ack_o && !wb_we_i && wb_adr_i == XCCS_STAT_OFS |->
      wb_dat_o[5:4] == {ref_r, $past(fifo_busy_i)}) else $error("status flags wrong");
   cov_refused: cover property (wr_cfg && fifo_busy_i);
   cov_tx_shared: cover property (cfg_r[0] && clk_in_i.tx_par[0]);
   cov_div_tick: cover property (|(cfg_r[15:12] & clk_in_i.rx_par));
endmodule : xccs_clock_select_chk
bind xccs_clock_select xccs_clock_select_chk u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
   .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .fifo_busy_i, .clk_in_i, .fifo_clk_o,
   .rx_div_phase_o);
`default_nettype wire

// >>> test_xccs_clock_select.sv
// testbench for the fifo clock select block
`timescale 1ns/100ps
`default_nettype none
module test_xccs_clock_select;
   import xccs_pkg::*;
   `include "xccs_ref.svh"
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, busy = 1'b0, chk_on = 1'b0, ack;
   logic [3:0] adr = 4'h0, sel = 4'h0, ph, ph_q, phase;
   logic [31:0] dat = 32'h0000_0000, q, q_o;
   logic [15:0] cfg_m = 16'h0004;
   // static route settings, each written only while the fifos are idle
   logic [15:0] cfgs [6] = '{16'h0001, 16'h0002, 16'h0004, 16'h0A51, 16'h0FF6, 16'hF004};
   xccs_clk_in_t clk_in;
   xccs_fifo_clk_t fclk, exp_clk;
   int err_total = 0, n_compared = 0, cyc_n = 0;
   xccs_fabric_model u_fab (.clk_i, .rst_i, .clk_in_o(clk_in));
   xccs_clock_select DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q_o), .wb_ack_o(ack), .fifo_busy_i(busy),
      .clk_in_i(clk_in), .fifo_clk_o(fclk), .rx_div_phase_o(phase));
   always #5 clk_i = ~clk_i;
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : complete_run
   task automatic check(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("CHECK FAILED %0t %s", $time, m);
      end
   endtask : check
   // one classic cycle; the config model follows the ack edge like the block
   task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, s, d};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      check(n < 20, "no ack");
      q = q_o;
      if (w && a == XCCS_CFG_OFS && !busy && s[0]) cfg_m[7:0] <= d[7:0];
      if (w && a == XCCS_CFG_OFS && !busy && s[1]) cfg_m[15:8] <= d[15:8];
      {cyc, stb} <= 2'b00;
   endtask : wb
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      wb(1'b0, a, 4'hF, 32'h0000_0000);
      check(q === e, "read data");
   endtask : rd
   // tick model; the hang limit sits here too
   always @(posedge clk_i) begin
      exp_clk <= rst_i ? '0 : xccs_ref_sel(cfg_m, clk_in, ph);
      // a divider that is switched off parks its phase low
      ph <= rst_i ? 4'h0 : (ph ^ (cfg_m[15:12] & clk_in.rx_par)) & cfg_m[15:12];
      ph_q <= rst_i ? 4'h0 : ph;
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         err_total++;
         complete_run();
      end
   end
   always @(negedge clk_i) begin
      if (chk_on) check(fclk === exp_clk, "fifo tick");
      if (chk_on) check(phase === ph_q, "divider phase");
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk_on <= 1'b1;
      rd(XCCS_CFG_OFS, 32'h0000_0004);
      rd(XCCS_STAT_OFS, 32'h0000_0000);
      rd(4'h8, 32'h0000_0000);
      wb(1'b1, XCCS_STAT_OFS, 4'hF, 32'hFFFF_FFFF);
      wb(1'b1, 4'hC, 4'hF, 32'hFFFF_FFFF);
      rd(XCCS_CFG_OFS, 32'h0000_0004);
      $display("test reset done");
      // every route, core overrides and the divider; upper lanes carry junk
      foreach (cfgs[j]) begin
         wb(1'b1, XCCS_CFG_OFS, 4'hF, {16'hFFFF, cfgs[j]});
         rd(XCCS_CFG_OFS, {16'h0000, cfgs[j]});
         repeat (40) @(posedge clk_i);
      end
      $display("test routes done");
      busy <= 1'b1;
      wb(1'b1, XCCS_CFG_OFS, 4'h3, 32'h0000_0001);
      rd(XCCS_CFG_OFS, 32'h0000_F004);
      wb(1'b0, XCCS_STAT_OFS, 4'hF, 32'h0000_0000);
      check(q[5:4] === 2'b11, "refused flag");
      busy <= 1'b0;
      wb(1'b1, XCCS_CFG_OFS, 4'h2, 32'h0000_0300);
      rd(XCCS_CFG_OFS, 32'h0000_0304);
      wb(1'b0, XCCS_STAT_OFS, 4'hF, 32'h0000_0000);
      check(q[5:4] === 2'b00, "refused flag clear");
      repeat (20) @(posedge clk_i);
      $display("test refusal done");
      complete_run();
   end
endmodule : test_xccs_clock_select
`default_nettype wire
